// ### core/bcmu_pkg.sv
package bcmu_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int BCMU_XLEN = 64;
  localparam int BCMU_WORD = 32;

  // ---------------------------------------------------------------------------
  // Major opcodes and function codes
  // ---------------------------------------------------------------------------
  localparam logic [6:0] BCMU_OPC_IMM = 7'h13;
  localparam logic [6:0] BCMU_OPC_WORD_IMM = 7'h1B;
  localparam logic [6:0] BCMU_OPC_REG = 7'h33;
  localparam logic [6:0] BCMU_F7_COUNT = 7'h30;
  localparam logic [6:0] BCMU_F7_MINMAX = 7'h05;
  localparam logic [6:0] BCMU_F7_NEG = 7'h20;
  localparam logic [2:0] BCMU_F3_COUNT = 3'h1;
  localparam logic [2:0] BCMU_F3_NEG = 3'h0;
  localparam logic [2:0] BCMU_F3_MAX = 3'h6;
  localparam logic [2:0] BCMU_F3_MAXU = 3'h7;
  localparam logic [4:0] BCMU_SEL_LEAD = 5'h00;
  localparam logic [4:0] BCMU_SEL_TRAIL = 5'h01;
  localparam logic [4:0] BCMU_SEL_POP = 5'h02;
  localparam logic [4:0] BCMU_REG_ZERO = 5'h00;

  // ---------------------------------------------------------------------------
  // Decoded operations
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    BCMU_OP_NONE = 4'b0000,
    BCMU_OP_LEAD = 4'b0001,
    BCMU_OP_LEAD_W = 4'b0010,
    BCMU_OP_TRAIL = 4'b0011,
    BCMU_OP_TRAIL_W = 4'b0100,
    BCMU_OP_POP = 4'b0101,
    BCMU_OP_POP_W = 4'b0110,
    BCMU_OP_MAX = 4'b0111,
    BCMU_OP_MAXU = 4'b1000,
    BCMU_OP_ABS = 4'b1001
  } bcmu_op_e;

  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [BCMU_XLEN-1:0] first_source_operand;
    logic [BCMU_XLEN-1:0] second_source_operand;
  } bcmu_req_s;

  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic fused;
    logic [BCMU_XLEN-1:0] data;
  } bcmu_rsp_s;

endpackage : bcmu_pkg

// ### core/bcmu_unit.sv
`timescale 1ns/1ps
`default_nettype none

module bcmu_unit #(
  parameter int XLEN = bcmu_pkg::BCMU_XLEN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pipeline request
  input wire bcmu_pkg::bcmu_req_s req,
  // Write-back
  output var bcmu_pkg::bcmu_rsp_s rsp
);
  import bcmu_pkg::*;

  localparam int CW = $clog2(XLEN + 1);
  localparam int PAD = XLEN - BCMU_WORD;

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  // The opcode map and the word variants are laid out for one register width;
  // another width would need another map, so it is refused outright.
  if (XLEN != BCMU_XLEN) begin : g_bad_xlen
    $error("bcmu_unit serves only the package register width");
  end
  if (BCMU_WORD >= XLEN) begin : g_bad_word
    $error("bcmu_unit needs a word narrower than the register");
  end

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  // Two stages keep a release near the clock edge from reaching the state flops.
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // Counting functions
  // ---------------------------------------------------------------------------
  function automatic logic [CW-1:0] lead_zeros(input logic [XLEN-1:0] v, input int top);
    logic [CW-1:0] n;
    logic hit;
    n = '0;
    hit = 1'b0;
    for (int i = XLEN - 1; i >= 0; i--) begin
      if (i <= top && !hit) begin
        if (v[i]) begin
          hit = 1'b1;
        end else begin
          n = n + 1'b1;
        end
      end
    end
    return n;
  endfunction : lead_zeros

  function automatic logic [CW-1:0] trail_zeros(input logic [XLEN-1:0] v, input int top);
    logic [CW-1:0] n;
    logic hit;
    n = '0;
    hit = 1'b0;
    for (int i = 0; i < XLEN; i++) begin
      if (i <= top && !hit) begin
        if (v[i]) begin
          hit = 1'b1;
        end else begin
          n = n + 1'b1;
        end
      end
    end
    return n;
  endfunction : trail_zeros

  function automatic logic [CW-1:0] pop_ones(input logic [XLEN-1:0] v, input int top);
    logic [CW-1:0] n;
    n = '0;
    for (int i = 0; i < XLEN; i++) begin
      if (i <= top) begin
        n = n + {{(CW-1){1'b0}}, v[i]};
      end
    end
    return n;
  endfunction : pop_ones

  // One map from selector to count kind serves both opcode rows.
  function automatic bcmu_op_e count_kind(input logic [4:0] s, input logic w);
    bcmu_op_e k;
    k = BCMU_OP_NONE;
    if (s == BCMU_SEL_LEAD) begin
      k = w ? BCMU_OP_LEAD_W : BCMU_OP_LEAD;
    end else if (s == BCMU_SEL_TRAIL) begin
      k = w ? BCMU_OP_TRAIL_W : BCMU_OP_TRAIL;
    end else if (s == BCMU_SEL_POP) begin
      k = w ? BCMU_OP_POP_W : BCMU_OP_POP;
    end
    return k;
  endfunction : count_kind

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  logic [6:0] opc;
  logic [6:0] f7;
  logic [2:0] f3;
  logic [4:0] sel;
  logic [4:0] rd;
  logic [4:0] src1_idx;
  logic [4:0] src2_idx;
  bcmu_op_e op;
  always_comb begin
    opc = req.instr[6:0];
    f7 = req.instr[31:25];
    f3 = req.instr[14:12];
    sel = req.instr[24:20];
    rd = req.instr[11:7];
    src1_idx = req.instr[19:15];
    src2_idx = req.instr[24:20];
    op = BCMU_OP_NONE;
    if (req.valid && f7 == BCMU_F7_COUNT && f3 == BCMU_F3_COUNT) begin
      if (opc == BCMU_OPC_IMM) begin
        op = count_kind(sel, 1'b0);
      end else if (opc == BCMU_OPC_WORD_IMM) begin
        op = count_kind(sel, 1'b1);
      end
    end else if (req.valid && opc == BCMU_OPC_REG && f7 == BCMU_F7_MINMAX) begin
      if (f3 == BCMU_F3_MAX) op = BCMU_OP_MAX;
      else if (f3 == BCMU_F3_MAXU) op = BCMU_OP_MAXU;
    end
  end

  // ---------------------------------------------------------------------------
  // Fusion tracking
  // ---------------------------------------------------------------------------
  // A negate leaves its destination here; a following signed larger-select that pairs
  // its source with that destination yields the absolute value in one step.
  logic neg_seen;
  logic [4:0] neg_src;
  logic [4:0] neg_dst;
  logic next_neg_seen;
  logic [4:0] next_neg_src;
  logic [4:0] next_neg_dst;
  // Any valid request in between breaks the pair; idle cycles keep it.
  logic is_neg;
  logic src_match;
  logic dst_match;
  logic fuse;
  always_comb begin
    is_neg = req.valid && opc == BCMU_OPC_REG && f7 == BCMU_F7_NEG && f3 == BCMU_F3_NEG
             && src1_idx == BCMU_REG_ZERO;
    src_match = src1_idx == neg_src;
    dst_match = src2_idx == neg_dst && neg_dst != BCMU_REG_ZERO;
    fuse = neg_seen && op == BCMU_OP_MAX && src_match && dst_match;
    next_neg_seen = neg_seen;
    next_neg_src = neg_src;
    next_neg_dst = neg_dst;
    if (req.valid) begin
      next_neg_seen = is_neg;
      next_neg_src = src2_idx;
      next_neg_dst = rd;
    end
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      neg_seen <= 1'b0;
      neg_src <= 5'h00;
      neg_dst <= 5'h00;
    end else begin
      neg_seen <= next_neg_seen;
      neg_src <= next_neg_src;
      neg_dst <= next_neg_dst;
    end
  end

  // ---------------------------------------------------------------------------
  // Word staging
  // ---------------------------------------------------------------------------
  // The word is lifted to the top and padded with ones below, so the full-width
  // leading scan serves the word form and stops at 32 for a zero word.
  logic [XLEN-1:0] word_top;
  for (genvar i = 0; i < BCMU_WORD; i++) begin : g_word_hi
    assign word_top[PAD+i] = req.first_source_operand[i];
  end
  for (genvar i = 0; i < PAD; i++) begin : g_word_lo
    assign word_top[i] = 1'b1;
  end

  // ---------------------------------------------------------------------------
  // Count and select results
  // ---------------------------------------------------------------------------
  // All results are formed in parallel; only the decoded one is registered.
  logic [CW-1:0] cnt_lead;
  logic [CW-1:0] cnt_lead_w;
  logic [CW-1:0] cnt_trail;
  logic [CW-1:0] cnt_trail_w;
  logic [CW-1:0] cnt_pop;
  logic [CW-1:0] cnt_pop_w;
  logic [XLEN-1:0] a;
  logic [XLEN-1:0] b;
  logic [XLEN-1:0] max_s;
  logic [XLEN-1:0] max_u;
  logic [XLEN-1:0] abs_v;
  always_comb begin
    a = req.first_source_operand;
    b = req.second_source_operand;
    cnt_lead = lead_zeros(a, XLEN - 1);
    cnt_lead_w = lead_zeros(word_top, XLEN - 1);
    cnt_trail = trail_zeros(a, XLEN - 1);
    cnt_trail_w = trail_zeros(a, BCMU_WORD - 1);
    cnt_pop = pop_ones(a, XLEN - 1);
    cnt_pop_w = pop_ones(a, BCMU_WORD - 1);
    max_s = ($signed(a) < $signed(b)) ? b : a;
    max_u = (a < b) ? b : a;
    // In the fused pair the second source holds the negated first, so its sign picks.
    abs_v = b[XLEN-1] ? a : b;
  end

  // ---------------------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------------------
  bcmu_rsp_s next_rsp;
  always_comb begin
    next_rsp.valid = req.valid && op != BCMU_OP_NONE;
    next_rsp.dest = rd;
    next_rsp.fused = fuse;
    next_rsp.data = '0;
    unique case (op)
      BCMU_OP_LEAD: next_rsp.data = XLEN'(cnt_lead);
      BCMU_OP_LEAD_W: next_rsp.data = XLEN'(cnt_lead_w);
      BCMU_OP_TRAIL: next_rsp.data = XLEN'(cnt_trail);
      BCMU_OP_TRAIL_W: next_rsp.data = XLEN'(cnt_trail_w);
      BCMU_OP_POP: next_rsp.data = XLEN'(cnt_pop);
      BCMU_OP_POP_W: next_rsp.data = XLEN'(cnt_pop_w);
      BCMU_OP_MAX: next_rsp.data = fuse ? abs_v : max_s;
      BCMU_OP_MAXU: next_rsp.data = max_u;
      default: next_rsp.data = '0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Result register
  // ---------------------------------------------------------------------------
  // The write port sees only flops, so the host pipeline gets a full cycle.
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

endmodule : bcmu_unit

`default_nettype wire

// ### tb/bcmu_props.sv
`timescale 1ns/1ps
`default_nettype none

module bcmu_props
  import bcmu_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic nrst,
  input wire bcmu_pkg::bcmu_req_s req,
  input wire bcmu_pkg::bcmu_rsp_s rsp
);
  // ---------------------------------------------------------------------------
  // Decode helpers; every answer is judged one cycle after its request.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic [63:0] a = req.first_source_operand;
  wire logic [63:0] b = req.second_source_operand;
  wire logic [4:0] sel = req.instr[24:20];
  wire logic [2:0] f3 = req.instr[14:12];
  wire logic cnt = req.valid && req.instr[31:25] == BCMU_F7_COUNT && f3 == BCMU_F3_COUNT;
  wire logic full = cnt && req.instr[6:0] == BCMU_OPC_IMM;
  wire logic word = cnt && req.instr[6:0] == BCMU_OPC_WORD_IMM;
  wire logic mm = req.valid && req.instr[6:0] == BCMU_OPC_REG && req.instr[31:25] == BCMU_F7_MINMAX;

  a_lead_zero: assert property (full && sel == BCMU_SEL_LEAD && a == '0 |=> rsp.valid && rsp.data == 64'h40)
    else $error("leading count of zero operand wrong");
  a_lead_top: assert property (full && sel == BCMU_SEL_LEAD && a[63] |=> rsp.valid && rsp.data == '0)
    else $error("leading count with top bit set wrong");
  a_lead_word: assert property (word && sel == BCMU_SEL_LEAD && a[31:0] == '0 |=> rsp.data == 64'h20)
    else $error("word leading count of zero word wrong");
  a_trail_low: assert property (full && sel == BCMU_SEL_TRAIL && a[0] |=> rsp.valid && rsp.data == '0)
    else $error("trailing count with bit zero set wrong");
  a_trail_word: assert property (word && sel == BCMU_SEL_TRAIL && a[31:0] == '0 |=> rsp.data == 64'h20)
    else $error("word trailing count of zero word wrong");
  a_pop_full: assert property (full && sel == BCMU_SEL_POP |=> rsp.data == $countones($past(a)))
    else $error("population count wrong");
  a_pop_word: assert property (word && sel == BCMU_SEL_POP |=> rsp.data == $countones($past(a[31:0])))
    else $error("word population count wrong");
  a_max_unsigned: assert property (mm && f3 == BCMU_F3_MAXU |=> rsp.data == ($past(a) < $past(b) ? $past(b) : $past(a)))
    else $error("unsigned larger select wrong");
  a_max_signed: assert property (mm && f3 == BCMU_F3_MAX |=> rsp.data == ($signed($past(a)) > $signed($past(b)) ? $past(a) : $past(b)))
    else $error("signed larger select wrong");
endmodule : bcmu_props

bind bcmu_unit bcmu_props u_props (.clk(clk), .nrst(nrst), .req(req), .rsp(rsp));
`default_nettype wire

// ### tb/bcmu_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none

module bcmu_pipe_model
  import bcmu_pkg::*;
(
  // Request towards the unit
  output var bcmu_pkg::bcmu_req_s req
);
  // ---------------------------------------------------------------------------
  // Issue side, called just after a rising edge.
  // ---------------------------------------------------------------------------
  initial req = '0;
  task automatic issue(input logic [31:0] i, input logic [63:0] a, input logic [63:0] b);
    #1;
    req = '{1'b1, i, a, b};
  endtask : issue
  // Idle cycles show inverted operands, so stale values are never mistaken for live ones.
  task automatic idle();
    #1;
    req = '{1'b0, ~req.instr, ~req.first_source_operand, ~req.second_source_operand};
  endtask : idle
endmodule : bcmu_pipe_model
`default_nettype wire

// ### tb/bit_count_maximum_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module bit_count_maximum_unit_tb_top;
  import bcmu_pkg::*;
  // ---------------------------------------------------------------------------
  // Clock, reset, instances and shared tasks
  // ---------------------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  bcmu_req_s req;
  bcmu_rsp_s rsp;
  int error_cnt = 0;
  int samples_checked = 0;
  initial forever #5 clk = ~clk;
  bcmu_pipe_model pipe (.req(req));
  bcmu_unit dut (.clk(clk), .nrst(nrst), .req(req), .rsp(rsp));

  function automatic logic [31:0] enc(input logic [6:0] f7, input logic [4:0] r2,
      input logic [4:0] r1, input logic [2:0] f3, input logic [4:0] rd, input logic [6:0] op);
    return {f7, r2, r1, f3, rd, op};
  endfunction : enc

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic run(input string nm, input logic [31:0] i, input logic [63:0] a,
      input logic [63:0] b, input logic [63:0] e, input logic ok);
    @(posedge clk);
    pipe.issue(i, a, b);
    @(posedge clk);
    pipe.idle();
    #1;
    chk({nm, " valid"}, {63'h0, ok}, {63'h0, rsp.valid});
    chk(nm, e, rsp.data);
    if (ok) chk({nm, " dest"}, {59'h0, i[11:7]}, {59'h0, rsp.dest});
  endtask : run

  task automatic rc(input string nm, input logic [4:0] s, input logic w, input logic [63:0] a,
      input logic [63:0] e);
    run(nm, enc(BCMU_F7_COUNT, s, 5'h02, BCMU_F3_COUNT, 5'h01,
        w ? BCMU_OPC_WORD_IMM : BCMU_OPC_IMM), a, 64'h0, e, 1'b1);
  endtask : rc

  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic t_count();
    rc("lz zero", BCMU_SEL_LEAD, 1'b0, 64'h0, 64'h40);
    rc("lz top", BCMU_SEL_LEAD, 1'b0, 64'h8000000000000000, 64'h0);
    rc("lz one", BCMU_SEL_LEAD, 1'b0, 64'h1, 64'h3F);
    rc("lzw zero", BCMU_SEL_LEAD, 1'b1, 64'hFFFFFFFF00000000, 64'h20);
    rc("lzw mid", BCMU_SEL_LEAD, 1'b1, 64'hFFFFFFFF00010000, 64'hF);
    rc("lzw top", BCMU_SEL_LEAD, 1'b1, 64'h80000000, 64'h0);
    rc("tz zero", BCMU_SEL_TRAIL, 1'b0, 64'h0, 64'h40);
    rc("tz low", BCMU_SEL_TRAIL, 1'b0, 64'hFFFFFFFFFFFFFFFF, 64'h0);
    rc("tz mid", BCMU_SEL_TRAIL, 1'b0, 64'h0000010000000000, 64'h28);
    rc("tzw zero", BCMU_SEL_TRAIL, 1'b1, 64'hFFFFFFFF00000000, 64'h20);
    rc("tzw top", BCMU_SEL_TRAIL, 1'b1, 64'h8000000080000000, 64'h1F);
    rc("pop all", BCMU_SEL_POP, 1'b0, 64'hFFFFFFFFFFFFFFFF, 64'h40);
    rc("pop ends", BCMU_SEL_POP, 1'b0, 64'h8000000000000001, 64'h2);
    rc("popw all", BCMU_SEL_POP, 1'b1, 64'hFFFFFFFFFFFFFFFF, 64'h20);
    run("count reg op", enc(BCMU_F7_COUNT, BCMU_SEL_LEAD, 5'h02, BCMU_F3_COUNT, 5'h01,
        BCMU_OPC_REG), 64'h0, 64'h0, 64'h0, 1'b0);
  endtask : t_count

  task automatic t_max();
    run("max", enc(BCMU_F7_MINMAX, 5'h03, 5'h02, BCMU_F3_MAX, 5'h04, BCMU_OPC_REG),
        64'hFFFFFFFFFFFFFFFF, 64'h1, 64'h1, 1'b1);
    chk("max unfused", 64'h0, {63'h0, rsp.fused});
    run("maxu", enc(BCMU_F7_MINMAX, 5'h03, 5'h02, BCMU_F3_MAXU, 5'h04, BCMU_OPC_REG),
        64'hFFFFFFFFFFFFFFFF, 64'h1, 64'hFFFFFFFFFFFFFFFF, 1'b1);
    run("maxu equal", enc(BCMU_F7_MINMAX, 5'h03, 5'h02, BCMU_F3_MAXU, 5'h04, BCMU_OPC_REG),
        64'h5, 64'h5, 64'h5, 1'b1);
  endtask : t_max

  task automatic t_fuse();
    @(posedge clk);
    pipe.issue(enc(BCMU_F7_NEG, 5'h05, BCMU_REG_ZERO, BCMU_F3_NEG, 5'h06, BCMU_OPC_REG),
        64'h0, 64'hFFFFFFFFFFFFFFF9);
    run("abs", enc(BCMU_F7_MINMAX, 5'h06, 5'h05, BCMU_F3_MAX, 5'h06, BCMU_OPC_REG),
        64'hFFFFFFFFFFFFFFF9, 64'h7, 64'h7, 1'b1);
    chk("fused", 64'h1, {63'h0, rsp.fused});
  endtask : t_fuse

  task automatic t_b2b();
    @(posedge clk);
    pipe.issue(enc(BCMU_F7_COUNT, BCMU_SEL_LEAD, 5'h02, BCMU_F3_COUNT, 5'h01, BCMU_OPC_IMM),
        64'h1, 64'h0);
    @(posedge clk);
    pipe.issue(enc(BCMU_F7_COUNT, BCMU_SEL_TRAIL, 5'h02, BCMU_F3_COUNT, 5'h01, BCMU_OPC_IMM),
        64'h100, 64'h0);
    #1;
    chk("b2b first", 64'h3F, rsp.data);
    @(posedge clk);
    pipe.idle();
    #1;
    chk("b2b second", 64'h8, rsp.data);
  endtask : t_b2b

  initial begin
    #200000;
    error_cnt++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk);
    t_count();
    t_max();
    t_fuse();
    t_b2b();
    test_done();
  end
endmodule : bit_count_maximum_unit_tb_top
`default_nettype wire
